// ===== core/epcd_pkg.sv
package epcd_pkg;

  // ********************************************************
  // Command opcodes
  // ********************************************************
  localparam logic [7:0] CMD_BOOST = 8'h06;
  localparam logic [7:0] CMD_SLEEP = 8'h07;
  localparam logic [7:0] CMD_PLANE1 = 8'h10;
  localparam logic [7:0] CMD_STOP = 8'h11;
  localparam logic [7:0] CMD_REFRESH = 8'h12;
  localparam logic [7:0] CMD_PLANE2 = 8'h13;
  localparam logic [7:0] CMD_RATE = 8'h30;
  localparam logic [7:0] CMD_TEMP = 8'h40;
  localparam logic [7:0] CMD_SRC = 8'h41;
  localparam logic [7:0] CMD_EXTW = 8'h42;
  localparam logic [7:0] CMD_EXTR = 8'h43;
  localparam logic [7:0] CMD_GAP = 8'h50;
  localparam logic [7:0] SLEEP_CODE = 8'hA5;

  // ********************************************************
  // Register offsets (opcode that reaches each register)
  // ********************************************************
  localparam logic [7:0] REG_FRAME_COMPLETE_STATUS = 8'h11;
  localparam logic [7:0] REG_FRAME_RATE_CONTROL = 8'h30;
  localparam logic [7:0] REG_TEMPERATURE_READING = 8'h40;
  localparam logic [7:0] REG_TEMPERATURE_SOURCE_SELECT = 8'h41;
  localparam logic [7:0] REG_EXTERNAL_SENSOR_WRITE = 8'h42;
  localparam logic [7:0] REG_EXTERNAL_SENSOR_READ = 8'h43;
  localparam logic [7:0] REG_VCOM_DATA_INTERVAL = 8'h50;

  // ********************************************************
  // Reset values and field positions
  // ********************************************************
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] RATE_RST = 8'h3C;
  localparam logic [7:0] SRC_RST = 8'h00;
  localparam logic [7:0] GAP_RST = 8'hD7;
  localparam logic [7:0] BOOST_RST = 8'h17;
  localparam int FLAG_BIT = 7;
  localparam int RATE_M_LSB = 3;
  localparam int RATE_N_LSB = 0;
  localparam int SRC_SEL_BIT = 7;
  localparam int SRC_OFS_LSB = 0;
  localparam int GAP_BORDER_LSB = 6;
  localparam int GAP_POL_LSB = 4;
  localparam int GAP_INT_LSB = 0;
  localparam int BOOST_STR_LSB = 3;
  localparam int BOOST_OFF_LSB = 0;
  localparam int EXT_CODE_LSB = 5;
  localparam logic [4:0] GAP_BASE_LINES = 5'h11;
  localparam logic [4:0] VBLANK_LINES = 5'h14;

  // ********************************************************
  // Frame sizes in bytes, one per resolution code
  // ********************************************************
  localparam logic [12:0] FRAME_BYTES_RES0 = 13'h0AC8;
  localparam logic [12:0] FRAME_BYTES_RES1 = 13'h0BD0;
  localparam logic [12:0] FRAME_BYTES_RES2 = 13'h1280;
  localparam logic [12:0] FRAME_BYTES_RES3 = 13'h1720;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam int SYS_CLK_MHZ = 100;
  localparam int REFRESH_TIME_US = 20000;
  localparam int REFRESH_CYCLES = REFRESH_TIME_US * SYS_CLK_MHZ;
  localparam int FIFO_WIDTH = 10;
  localparam int FIFO_DEPTH = 8;

  // ********************************************************
  // Types
  // ********************************************************
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WRITE = 2'b01,
    PH_READ = 2'b10,
    PH_SLEEP = 2'b11
  } epcd_phase_t;

  typedef enum logic [2:0] {
    WV_FLOAT = 3'b000,
    WV_BLACK = 3'b001,
    WV_WHITE = 3'b010,
    WV_RED = 3'b011,
    WV_WW = 3'b100,
    WV_BW = 3'b101,
    WV_WB = 3'b110,
    WV_BB = 3'b111
  } epcd_wave_t;

endpackage

// ===== core/epcd_core.sv
`timescale 1ns/10ps
`default_nettype none

// ********************************************************
// Pixel byte FIFO
// ********************************************************
module epcd_fifo #(
  parameter int W = 10,
  parameter int D = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } epcd_fifo_st_t;

  epcd_fifo_st_t st_r;
  epcd_fifo_st_t st_nxt;
  logic push;
  logic pop;

  // Flags from the count
  assign in_ready = (st_r.cnt != (AW+1)'(D));
  assign out_valid = (st_r.cnt != '0);
  assign out_data = st_r.mem[st_r.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointer and count update
  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wp] = in_data;
      st_nxt.wp = (st_r.wp == AW'(D-1)) ? '0 : st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = (st_r.rp == AW'(D-1)) ? '0 : st_r.rp + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// ********************************************************
// Command and data path
// ********************************************************
// Behaviour
// - Command/data line low marks opcode, high marks data for latest command.
// - Panel colour bit picks three-colour planes or two-colour old/new planes.
// - Booster strength codes 000b..111b decode to strengths 1..8.
// - Booster off-time codes decode 0.27us up to 6.58us.
// - Opcode 07h enters deep sleep only when its parameter is A5h.
// - Deep sleep ignores the link until hardware reset.
// - Opcode 10h streams following bytes into SRAM plane one.
// - Eight pixels per byte, first in bit 7, stored in transfer order.
// - Opcode 13h streams following bytes into SRAM plane two.
// - Opcode 11h returns status with frame-complete flag in bit 7.
// - Transfer or stop ending with flag set starts refresh, busy low.
// - Opcode 12h starts refresh and holds busy low meanwhile.
// - Opcode 30h loads frame-rate multiplier and divider, reset 3Ch.
// - Opcode 40h returns two temperature bytes from selected sensor.
// - Temperature codes are two's-complement whole degrees.
// - Opcode 41h selects sensor in bit 7 and a signed 4-bit offset.
// - Opcode 42h takes attribute, high and low bytes for sensor write.
// - Opcode 43h returns external sensor read, high byte first.
// - Opcode 50h loads border, polarity, interval; blanking fixed at 20 lines.
// - Three-colour border codes choose black, white, red, floating by polarity.
// - Three-colour pixel waveform from red and black/white bits and polarity.
// - Two-colour pixel pair selects one of four transition waveforms.
module epcd_core #(
  parameter int REFRESH_LEN = epcd_pkg::REFRESH_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Serial link
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdin,
  input wire logic spi_dc,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  // Panel configuration
  input wire logic two_colour_mode,
  input wire logic [1:0] res_sel,
  // SRAM write port
  output logic pixel_ready,
  input wire logic sram_ready,
  output logic sram_we,
  output logic sram_plane,
  output logic [12:0] sram_addr,
  output logic [7:0] sram_wdata,
  // Refresh control
  output logic busy_n,
  output logic refresh_start,
  output logic deep_sleep,
  // Booster settings
  output logic [3:0] boost_two_strength,
  output logic [9:0] boost_two_offtime,
  output logic [3:0] boost_three_strength,
  output logic [9:0] boost_three_offtime,
  // Frame rate
  output logic [2:0] frame_rate_m,
  output logic [2:0] frame_rate_n,
  // Temperature sensors
  input wire logic [7:0] internal_temp_code,
  output logic temp_sense_req,
  output logic i2c_write_req,
  output logic [7:0] i2c_write_attr,
  output logic [7:0] i2c_write_high,
  output logic [7:0] i2c_write_low,
  output logic i2c_read_req,
  input wire logic [15:0] i2c_read_data,
  // Waveform selection
  output logic [1:0] border_select,
  output logic [1:0] data_polarity,
  output logic [4:0] vcom_gap_lines,
  output logic [4:0] vblank_lines,
  output epcd_pkg::epcd_wave_t border_wave,
  input wire logic [1:0] pix_pair,
  output epcd_pkg::epcd_wave_t pix_wave
);
  import epcd_pkg::*;

  typedef struct packed {
    logic [2:0] sclk_s;
    logic [2:0] cs_s;
    logic [1:0] sdin_s;
    logic [1:0] dc_s;
    epcd_phase_t phase;
    logic [2:0] bit_cnt;
    logic [7:0] rx_sh;
    logic [7:0] cmd;
    logic [1:0] pidx;
    logic [7:0] tx_sh;
    logic [7:0] tx_next;
    logic [7:0] boost_two;
    logic [7:0] boost_three;
    logic [7:0] rate;
    logic [7:0] src;
    logic [7:0] gap;
    logic [7:0] ext_attr;
    logic [7:0] ext_high;
    logic [7:0] ext_low;
    logic [12:0] ptr1;
    logic [12:0] ptr2;
    logic done1;
    logic done2;
    logic busy;
    logic [31:0] busy_cnt;
    logic start_p;
    logic temp_p;
    logic extw_p;
    logic extr_p;
    logic we;
    logic plane;
    logic [12:0] addr;
    logic [7:0] wdata;
    epcd_wave_t bwave;
    epcd_wave_t pwave;
  } epcd_core_st_t;

  // ********************************************************
  // Decoders
  // ********************************************************
  // Strength is the code plus one
  function automatic logic [3:0] strength_of(input logic [2:0] code);
    strength_of = {1'b0, code} + 4'h1;
  endfunction

  // Off time in 10 ns units
  function automatic logic [9:0] offtime_of(input logic [2:0] code);
    case (code)
      3'h0: offtime_of = 10'h01B;
      3'h1: offtime_of = 10'h022;
      3'h2: offtime_of = 10'h028;
      3'h3: offtime_of = 10'h036;
      3'h4: offtime_of = 10'h050;
      3'h5: offtime_of = 10'h09A;
      3'h6: offtime_of = 10'h14E;
      default: offtime_of = 10'h292;
    endcase
  endfunction

  // Pixel waveform
  function automatic epcd_wave_t pixel_wave_of(input logic two, input logic [1:0] pol,
                                               input logic [1:0] pair);
    logic [1:0] p;
    p = pair ^ {2{pol[0]}};
    if (two) begin
      case (p)
        2'b00: pixel_wave_of = WV_WW;
        2'b01: pixel_wave_of = WV_BW;
        2'b10: pixel_wave_of = WV_WB;
        default: pixel_wave_of = WV_BB;
      endcase
    end else if (pair[1] ^ pol[1]) begin
      pixel_wave_of = WV_RED;
    end else begin
      pixel_wave_of = (pair[0] ^ pol[0]) ? WV_BLACK : WV_WHITE;
    end
  endfunction

  // Border waveform
  function automatic epcd_wave_t border_wave_of(input logic two, input logic pol0,
                                                input logic [1:0] sel);
    logic [1:0] s;
    s = pol0 ? sel : ~sel;
    if (two) begin
      case (sel)
        2'b01: border_wave_of = pol0 ? WV_WB : WV_BW;
        2'b10: border_wave_of = pol0 ? WV_BW : WV_WB;
        default: border_wave_of = WV_FLOAT;
      endcase
    end else begin
      case (s)
        2'b00: border_wave_of = WV_BLACK;
        2'b01: border_wave_of = WV_WHITE;
        2'b10: border_wave_of = WV_RED;
        default: border_wave_of = WV_FLOAT;
      endcase
    end
  endfunction

  epcd_core_st_t st_r;
  epcd_core_st_t st_nxt;
  logic fifo_in_valid;
  logic [FIFO_WIDTH-1:0] fifo_in_data;
  logic fifo_out_valid;
  logic [FIFO_WIDTH-1:0] fifo_out_data;
  logic [12:0] frame_bytes;
  logic flag;

  // ********************************************************
  // Buffer between link and SRAM
  // ********************************************************
  // Full buffer drops bytes
  epcd_fifo #(.W(FIFO_WIDTH), .D(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(fifo_in_valid),
    .in_ready(pixel_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(sram_ready),
    .out_data(fifo_out_data)
  );

  // Frame size from resolution code
  always_comb begin
    case (res_sel)
      2'b00: frame_bytes = FRAME_BYTES_RES0;
      2'b01: frame_bytes = FRAME_BYTES_RES1;
      2'b10: frame_bytes = FRAME_BYTES_RES2;
      default: frame_bytes = FRAME_BYTES_RES3;
    endcase
  end

  assign flag = st_r.done1 & st_r.done2;

  // ********************************************************
  // Next-state logic
  // ********************************************************
  always_comb begin
    logic rise;
    logic fall;
    logic byte_done;
    logic [7:0] rx_byte;
    logic is_data;
    logic [12:0] waddr;
    logic [7:0] tval;
    rise = st_r.sclk_s[1] & ~st_r.sclk_s[2];
    fall = ~st_r.sclk_s[1] & st_r.sclk_s[2];
    byte_done = 1'b0;
    rx_byte = {st_r.rx_sh[6:0], st_r.sdin_s[1]};
    is_data = st_r.dc_s[1];
    waddr = '0;
    tval = '0;
    fifo_in_valid = 1'b0;
    fifo_in_data = '0;
    st_nxt = st_r;
    st_nxt.sclk_s = {st_r.sclk_s[1:0], spi_sclk};
    st_nxt.cs_s = {st_r.cs_s[1:0], spi_cs_n};
    st_nxt.sdin_s = {st_r.sdin_s[0], spi_sdin};
    st_nxt.dc_s = {st_r.dc_s[0], spi_dc};
    st_nxt.start_p = 1'b0;
    st_nxt.temp_p = 1'b0;
    st_nxt.extw_p = 1'b0;
    st_nxt.extr_p = 1'b0;
    st_nxt.we = 1'b0;

    // Bits in, MSB first
    if (st_r.cs_s[1] || st_r.phase == PH_SLEEP) begin
      st_nxt.bit_cnt = '0;
    end else if (rise) begin
      st_nxt.rx_sh = rx_byte;
      st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
      byte_done = (st_r.bit_cnt == 3'h7);
    end else if (fall && st_r.bit_cnt != 3'h0 && st_r.phase == PH_READ) begin
      st_nxt.tx_sh = {st_r.tx_sh[6:0], 1'b0};
    end

    // Byte interpretation by command/data line
    case (st_r.phase)
      PH_SLEEP: begin
        st_nxt.phase = PH_SLEEP;
      end
      PH_IDLE, PH_WRITE, PH_READ: begin
        if (byte_done && !is_data) begin
          st_nxt.cmd = rx_byte;
          st_nxt.pidx = '0;
          st_nxt.phase = PH_WRITE;
          // Full frame kicks refresh
          if ((st_r.cmd == CMD_PLANE1 || st_r.cmd == CMD_PLANE2) && flag) begin
            st_nxt.start_p = 1'b1;
          end
          case (rx_byte)
            CMD_PLANE1: st_nxt.done1 = 1'b0;
            CMD_PLANE2: st_nxt.done2 = 1'b0;
            CMD_STOP: begin
              st_nxt.phase = PH_READ;
              st_nxt.tx_sh = {flag, 7'h00};
              if (flag) begin
                st_nxt.start_p = 1'b1;
              end
            end
            CMD_REFRESH: st_nxt.start_p = 1'b1;
            CMD_TEMP: begin
              // Offset in whole degrees
              if (st_r.src[SRC_SEL_BIT]) begin
                tval = i2c_read_data[15:8] + {{4{st_r.src[3]}}, st_r.src[3:0]};
                st_nxt.tx_sh = tval;
                st_nxt.tx_next = {i2c_read_data[7:EXT_CODE_LSB], 5'h00};
              end else begin
                tval = internal_temp_code + {{4{st_r.src[3]}}, st_r.src[3:0]};
                st_nxt.tx_sh = tval;
                st_nxt.tx_next = 8'h00;
              end
              st_nxt.phase = PH_READ;
              st_nxt.temp_p = 1'b1;
            end
            CMD_EXTR: begin
              st_nxt.phase = PH_READ;
              st_nxt.tx_sh = i2c_read_data[15:8];
              st_nxt.tx_next = i2c_read_data[7:0];
              st_nxt.extr_p = 1'b1;
            end
            default: st_nxt.phase = PH_WRITE;
          endcase
        end else if (byte_done && st_r.phase == PH_READ) begin
          st_nxt.tx_sh = st_r.tx_next;
          st_nxt.tx_next = 8'h00;
        end else if (byte_done && st_r.phase == PH_WRITE) begin
          st_nxt.pidx = (st_r.pidx == 2'h3) ? 2'h3 : st_r.pidx + 2'h1;
          case (st_r.cmd)
            CMD_BOOST: begin
              if (st_r.pidx == 2'h1) st_nxt.boost_two = rx_byte;
              if (st_r.pidx == 2'h2) st_nxt.boost_three = {2'b00, rx_byte[5:0]};
            end
            CMD_SLEEP: begin
              if (st_r.pidx == 2'h0 && rx_byte == SLEEP_CODE) begin
                st_nxt.phase = PH_SLEEP;
              end
            end
            CMD_PLANE1, CMD_PLANE2: begin
              fifo_in_valid = 1'b1;
              fifo_in_data = {(st_r.pidx == 2'h0), (st_r.cmd == CMD_PLANE2), rx_byte};
            end
            CMD_RATE: st_nxt.rate = {2'b00, rx_byte[5:0]};
            CMD_SRC: st_nxt.src = rx_byte;
            CMD_GAP: st_nxt.gap = rx_byte;
            CMD_EXTW: begin
              if (st_r.pidx == 2'h0) st_nxt.ext_attr = rx_byte;
              if (st_r.pidx == 2'h1) st_nxt.ext_high = rx_byte;
              if (st_r.pidx == 2'h2) begin
                st_nxt.ext_low = rx_byte;
                st_nxt.extw_p = 1'b1;
              end
            end
            default: st_nxt.pidx = st_r.pidx;
          endcase
        end
      end
      default: st_nxt.phase = PH_IDLE;
    endcase

    // SRAM drain; first byte restarts plane
    if (fifo_out_valid && sram_ready) begin
      if (fifo_out_data[9]) begin
        waddr = '0;
      end else begin
        waddr = fifo_out_data[8] ? st_r.ptr2 : st_r.ptr1;
      end
      st_nxt.we = (waddr != frame_bytes);
      st_nxt.plane = fifo_out_data[8];
      st_nxt.addr = waddr;
      st_nxt.wdata = fifo_out_data[7:0];
      if (waddr != frame_bytes) begin
        if (fifo_out_data[8]) begin
          st_nxt.ptr2 = waddr + 13'h1;
          st_nxt.done2 = (waddr + 13'h1 == frame_bytes);
        end else begin
          st_nxt.ptr1 = waddr + 13'h1;
          st_nxt.done1 = (waddr + 13'h1 == frame_bytes);
        end
      end
    end

    // Refresh timer holding busy low
    if (st_nxt.start_p) begin
      st_nxt.busy = 1'b1;
      st_nxt.busy_cnt = 32'(REFRESH_LEN - 1);
    end else if (st_r.busy) begin
      if (st_r.busy_cnt == 32'h0) begin
        st_nxt.busy = 1'b0;
      end else begin
        st_nxt.busy_cnt = st_r.busy_cnt - 32'h1;
      end
    end

    // Registered waveform choices
    st_nxt.bwave = border_wave_of(two_colour_mode, st_r.gap[GAP_POL_LSB],
                                  st_r.gap[GAP_BORDER_LSB +: 2]);
    st_nxt.pwave = pixel_wave_of(two_colour_mode, st_r.gap[GAP_POL_LSB +: 2], pix_pair);
  end

  // ********************************************************
  // State register
  // ********************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      st_r.sclk_s <= 3'h0;
      st_r.cs_s <= 3'h7;
      st_r.phase <= PH_IDLE;
      st_r.boost_two <= BOOST_RST;
      st_r.boost_three <= BOOST_RST;
      st_r.rate <= RATE_RST;
      st_r.src <= SRC_RST;
      st_r.gap <= GAP_RST;
      st_r.bwave <= WV_FLOAT;
      st_r.pwave <= WV_WW;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  assign spi_sdo = st_r.tx_sh[7];
  assign spi_sdo_oe = (st_r.phase == PH_READ) & ~st_r.cs_s[1];
  assign sram_we = st_r.we;
  assign sram_plane = st_r.plane;
  assign sram_addr = st_r.addr;
  assign sram_wdata = st_r.wdata;
  assign busy_n = ~st_r.busy;
  assign refresh_start = st_r.start_p;
  assign deep_sleep = (st_r.phase == PH_SLEEP);
  assign boost_two_strength = strength_of(st_r.boost_two[BOOST_STR_LSB +: 3]);
  assign boost_two_offtime = offtime_of(st_r.boost_two[BOOST_OFF_LSB +: 3]);
  assign boost_three_strength = strength_of(st_r.boost_three[BOOST_STR_LSB +: 3]);
  assign boost_three_offtime = offtime_of(st_r.boost_three[BOOST_OFF_LSB +: 3]);
  assign frame_rate_m = st_r.rate[RATE_M_LSB +: 3];
  assign frame_rate_n = st_r.rate[RATE_N_LSB +: 3];
  assign temp_sense_req = st_r.temp_p;
  assign i2c_write_req = st_r.extw_p;
  assign i2c_write_attr = st_r.ext_attr;
  assign i2c_write_high = st_r.ext_high;
  assign i2c_write_low = st_r.ext_low;
  assign i2c_read_req = st_r.extr_p;
  assign border_select = st_r.gap[GAP_BORDER_LSB +: 2];
  assign data_polarity = st_r.gap[GAP_POL_LSB +: 2];
  assign vcom_gap_lines = GAP_BASE_LINES - {1'b0, st_r.gap[GAP_INT_LSB +: 4]};
  assign vblank_lines = VBLANK_LINES;
  assign border_wave = st_r.bwave;
  assign pix_wave = st_r.pwave;
endmodule

`default_nettype wire

// ===== tb/epcd_core_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// ********************************
// Port checker
// ********************************
module epcd_core_asserts (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Refresh and sleep
  input wire logic busy_n,
  input wire logic refresh_start,
  input wire logic deep_sleep,
  input wire logic temp_sense_req,
  // Waveform selection
  input wire logic [4:0] vblank_lines,
  input wire logic two_colour_mode,
  input wire logic [1:0] data_polarity,
  input wire logic [1:0] border_select,
  input wire logic [1:0] pix_pair,
  input wire epcd_pkg::epcd_wave_t border_wave,
  input wire epcd_pkg::epcd_wave_t pix_wave
);
  import epcd_pkg::*;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // Busy only falls together with a start
  property p_busy_start;
    $fell(busy_n) |-> refresh_start;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy fell without start");
  // Start holds busy low
  property p_busy_hold;
    refresh_start |-> !busy_n ##1 (!busy_n) [*8];
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy not held low");
  // Only a reset ends deep sleep
  property p_sleep_stays;
    deep_sleep |=> deep_sleep;
  endproperty
  a_sleep_stays: assert property (p_sleep_stays) else $error("left deep sleep");
  // Asleep: no command acts
  property p_sleep_quiet;
    deep_sleep |-> !temp_sense_req && !refresh_start;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("command acted in sleep");
  // Fixed blanking
  property p_blank;
    vblank_lines == 5'h14;
  endproperty
  a_blank: assert property (p_blank) else $error("blanking not fixed");
  // Three colours, polarity bit 0 set: code 11 floats
  property p_border;
    !two_colour_mode && data_polarity[0] && border_select == 2'h3 |=> border_wave == WV_FLOAT;
  endproperty
  a_border: assert property (p_border) else $error("border wave wrong");
  // Red pixel takes red wave
  property p_tri_red;
    !two_colour_mode && data_polarity == 2'h1 && pix_pair[1] |=> pix_wave == WV_RED;
  endproperty
  a_tri_red: assert property (p_tri_red) else $error("red pixel wave wrong");
  // Two colours, polarity bit 0 clear: 00 stays white
  property p_two_ww;
    two_colour_mode && !data_polarity[0] && pix_pair == 2'h0 |=> pix_wave == WV_WW;
  endproperty
  a_two_ww: assert property (p_two_ww) else $error("pair wave wrong");
endmodule
bind epcd_core epcd_core_asserts u_chk (.sys_clk(sys_clk), .rst(rst), .busy_n(busy_n),
  .refresh_start(refresh_start), .deep_sleep(deep_sleep), .temp_sense_req(temp_sense_req),
  .vblank_lines(vblank_lines), .two_colour_mode(two_colour_mode),
  .data_polarity(data_polarity), .border_select(border_select), .pix_pair(pix_pair),
  .border_wave(border_wave), .pix_wave(pix_wave));
`default_nettype wire

// ===== tb/epcd_host.sv
`timescale 1ns/10ps
`default_nettype none
// ********************************
// Host link model
// ********************************
module epcd_host (
  // Clock
  input wire logic sys_clk,
  // Serial link
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_sdin,
  output logic spi_dc,
  input wire logic spi_sdo
);
  // Idle, deselected
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdin = 1'b0;
    spi_dc = 1'b0;
  end
  // One byte, MSB first
  task automatic xfer(input logic dc, input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      repeat (8) @(posedge sys_clk);
      spi_sclk <= 1'b0;
      spi_cs_n <= 1'b0;
      spi_dc <= dc;
      spi_sdin <= tx[i];
      repeat (8) @(posedge sys_clk);
      spi_sclk <= 1'b1;
      rx[i] = spi_sdo;
    end
    repeat (8) @(posedge sys_clk);
    spi_sclk <= 1'b0;
    spi_cs_n <= 1'b1;
    spi_sdin <= ~tx[0]; // No stale bit once released
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_epaper_command_datapath.sv
`timescale 1ns/10ps
`default_nettype none
module tb_epaper_command_datapath;
  import epcd_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, two_colour_mode = 1'b0, sram_ready = 1'b1;
  logic [1:0] res_sel = 2'h0, pix_pair = 2'h2, bsel, dpol;
  logic [7:0] internal_temp_code = 8'h31, wa, wh, wl, rx, sram_wdata;
  logic [15:0] i2c_read_data = 16'hA55A;
  logic spi_sclk, spi_cs_n, spi_sdin, spi_dc, spi_sdo, sram_we, sram_plane, busy_n, deep_sleep;
  logic [12:0] sram_addr;
  logic [3:0] b2s, b3s;
  logic [9:0] b2o, b3o;
  logic [2:0] frm, frn;
  logic [4:0] gap;
  epcd_wave_t pw;
  logic [21:0] q[$];
  int errors = 0, check_count = 0;
  // ********************************
  // Clock, host, design
  // ********************************
  always #5 sys_clk = ~sys_clk;
  epcd_host host (.sys_clk(sys_clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_sdin(spi_sdin), .spi_dc(spi_dc), .spi_sdo(spi_sdo));
  epcd_core #(.REFRESH_LEN(50)) dut (.sys_clk(sys_clk), .rst(rst), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_sdin(spi_sdin), .spi_dc(spi_dc), .spi_sdo(spi_sdo),
    .spi_sdo_oe(), .two_colour_mode(two_colour_mode), .res_sel(res_sel), .pixel_ready(),
    .sram_ready(sram_ready), .sram_we(sram_we), .sram_plane(sram_plane),
    .sram_addr(sram_addr), .sram_wdata(sram_wdata), .busy_n(busy_n), .refresh_start(),
    .deep_sleep(deep_sleep), .boost_two_strength(b2s), .boost_two_offtime(b2o),
    .boost_three_strength(b3s), .boost_three_offtime(b3o), .frame_rate_m(frm),
    .frame_rate_n(frn), .internal_temp_code(internal_temp_code), .temp_sense_req(),
    .i2c_write_req(), .i2c_write_attr(wa), .i2c_write_high(wh), .i2c_write_low(wl),
    .i2c_read_req(), .i2c_read_data(i2c_read_data), .border_select(bsel),
    .data_polarity(dpol), .vcom_gap_lines(gap), .vblank_lines(), .border_wave(),
    .pix_pair(pix_pair), .pix_wave(pw));
  // Log SRAM writes
  always @(posedge sys_clk) if (sram_we === 1'b1) q.push_back({sram_plane, sram_addr, sram_wdata});
  task chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task cmd(input logic [7:0] op);
    host.xfer(1'b0, op, rx);
  endtask
  task dat(input logic [7:0] d);
    host.xfer(1'b1, d, rx);
  endtask
  task complete_run;
    $display("checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (40000) @(posedge sys_clk);
    errors++;
    complete_run();
  end
  // ********************************
  // Tests
  // ********************************
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk("rate", 24'h3C, {frm, frn});
    chk("gap", 24'hD0A, {bsel, dpol, 3'h0, gap});
    cmd(CMD_RATE);
    dat(8'h0B);
    chk("rate", 24'h0B, {frm, frn});
    cmd(CMD_BOOST);
    dat(8'h17);
    dat(8'h3F);
    dat(8'h00);
    chk("boost", 24'h8292, {b2s, 2'h0, b2o});
    chk("boost3", 24'h101B, {b3s, 2'h0, b3o});
    cmd(CMD_EXTW);
    dat(8'h4B);
    dat(8'h12);
    dat(8'h34);
    chk("extw", 24'h4B1234, {wa, wh, wl});
    $display("regs done");
    cmd(CMD_SRC);
    dat(8'h0F);
    cmd(CMD_TEMP);
    dat(8'h00);
    chk("temp", 24'h30, rx);
    dat(8'h00);
    chk("temp low", 24'h00, rx);
    cmd(CMD_EXTR);
    dat(8'h00);
    chk("ext high", 24'hA5, rx);
    dat(8'h00);
    chk("ext low", 24'h5A, rx);
    $display("temp done");
    cmd(CMD_PLANE1);
    dat(8'h81);
    dat(8'hC3);
    cmd(CMD_PLANE2);
    dat(8'h5A);
    cmd(CMD_STOP);
    dat(8'h00);
    chk("flag", 24'h00, rx);
    chk("busy", 24'h1, busy_n);
    chk("writes", 24'h3, q.size());
    chk("w0", 24'h000081, q[0]);
    chk("w1", 24'h0001C3, q[1]);
    chk("w2", 24'h20005A, q[2]);
    cmd(CMD_REFRESH);
    chk("busy", 24'h0, busy_n);
    repeat (20001) @(posedge sys_clk);
    repeat (200) if (busy_n !== 1'b1) @(posedge sys_clk);
    chk("busy", 24'h1, busy_n);
    $display("planes done");
    cmd(CMD_GAP);
    dat(8'hC2);
    two_colour_mode <= 1'b1;
    pix_pair <= 2'h0;
    repeat (3) @(posedge sys_clk);
    chk("gap", 24'h0F, gap);
    chk("wave", {21'h0, WV_WW}, pw);
    $display("waveform done");
    cmd(CMD_SLEEP);
    dat(8'h00);
    chk("sleep", 24'h0, deep_sleep);
    cmd(CMD_SLEEP);
    dat(SLEEP_CODE);
    chk("sleep", 24'h1, deep_sleep);
    cmd(CMD_RATE);
    dat(8'h3C);
    chk("rate", 24'h0B, {frm, frn});
    $display("sleep done");
    complete_run();
  end
endmodule
`default_nettype wire
